// ### logic/cgs_top.sv
/*
  cgs_top: clock generation sequencer. Sequences the slow RC clock and the
  fast clock (PLL or external input), gates them to peripherals after the
  stabilization counts, selects the system clock and drives the slow clock
  on port B bit 7.
  Assumes the oscillator cores are outside: slow_osc_tick_i and pll_tick_i are
  one-cycle pulses on clk_i, one per oscillator period; external clock pins
  are asynchronous and are synchronized here.
*/
// Decided for this implementation: the address-and-strobe port.
// Function
// - reset starts slow oscillator, waits 256 counts
// - stop halts slow oscillator, interrupt restarts
// - after stop wait 32 slow counts
// - processor runs slow clock after power-up
// - PLL runs at 512 times slow reference
// - lock flag set when PLL within tolerance
// - PLL mode waits 8192 PLL pulses
// - PLL mode leaves clock pins as inputs
// - external mode waits 128 input edges
// - port A bit 2 wins over bit 6
// - fast oscillation starts on enable write
// - stop halts fast clock, release restabilizes
// - wait 128 external or 8192 PLL pulses
// - system clock picks fast or slow clock
// - stall processor until slow clock supplied
// - stall processor until fast clock supplied
// - function selects put slow clock on pin
// - latch bit ignored while clock drives pin
// - enable off forces slow system clock
// - source select changes only while disabled
// - divider selects 1,2,4,8; PLL code 0 halves
// - lock flag reads 1 only when locked
`timescale 1ns/10ps
`default_nettype none
module cgs_top #(
  parameter int SLOW_WAIT_RESET = cgs_pkg::SLOW_WAIT_RESET,
  parameter int SLOW_WAIT_STOP = cgs_pkg::SLOW_WAIT_STOP,
  parameter int FAST_WAIT_PLL = cgs_pkg::FAST_WAIT_PLL,
  parameter int FAST_WAIT_EXT = cgs_pkg::FAST_WAIT_EXT,
  parameter int PLL_LOCK_CYCLES = cgs_pkg::PLL_LOCK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // mcu control
  input wire logic stop_enter_i,
  input wire logic stop_release_i,
  input wire logic sys_clk_select_i,
  // oscillator cores
  input wire logic slow_osc_tick_i,
  input wire logic pll_tick_i,
  input wire logic pll_in_window_i,
  output logic slow_osc_run_o,
  output logic pll_run_o,
  // external clock pins
  input wire logic port_a_bit2_pin_i,
  input wire logic port_b_bit6_pin_i,
  input wire logic pa2_clk_sel_i,
  input wire logic pb6_clk_sel_i,
  output logic pa2_gpio_ok_o,
  output logic pb6_gpio_ok_o,
  // clock enables out
  output logic slow_clock_o,
  output logic fast_clock_o,
  output logic sys_tick_o,
  output logic sys_fast_o,
  output logic cpu_stall_o,
  // port B bit 7
  output logic port_b_bit7_pin_o,
  output logic port_b_bit7_pin_oe_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0] div_r;
  logic src_r;
  logic [1:0] outdiv_r;
  logic fast_osc_enable_r;
  logic syssel_r;
  logic lock_r;
  logic [7:0] pb_latch_r;
  logic [7:0] pb_dir_r;
  logic [7:0] pb_cfg_lo_r;
  logic [7:0] pb_cfg_hi_r;
  logic [7:0] pb_fsel_lo_r;
  logic [7:0] pb_fsel_hi_r;
  logic stopped_r;
  logic sw_sel_fast_r;
  logic [7:0] rd_nxt;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_r <= cgs_pkg::DIV_RST;
      src_r <= cgs_pkg::SRC_PLL;
      outdiv_r <= cgs_pkg::OUTDIV_RST;
    end
    else if (wr_i && hit(addr_i, cgs_pkg::ADDR_FREQ_A))
    begin
      div_r <= wdata_i[cgs_pkg::DIV_LSB +: 2];
      outdiv_r <= wdata_i[cgs_pkg::OUTDIV_LSB +: 2];
      if (!fast_osc_enable_r)
        src_r <= wdata_i[cgs_pkg::SRC_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fast_osc_enable_r <= 1'b0;
      sw_sel_fast_r <= 1'b0;
    end
    else if (wr_i && hit(addr_i, cgs_pkg::ADDR_FREQ_B))
    begin
      fast_osc_enable_r <= wdata_i[cgs_pkg::FAST_OSC_ENABLE_BIT];
      sw_sel_fast_r <= wdata_i[cgs_pkg::SYSSEL_BIT];
    end
  end

  // select bit reads 0 while the fast oscillator is disabled
  assign syssel_r = sw_sel_fast_r & fast_osc_enable_r;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pb_latch_r <= cgs_pkg::PB_RST;
      pb_dir_r <= cgs_pkg::PB_RST;
      pb_cfg_lo_r <= cgs_pkg::PB_RST;
      pb_cfg_hi_r <= cgs_pkg::PB_RST;
      pb_fsel_lo_r <= cgs_pkg::PB_RST;
      pb_fsel_hi_r <= cgs_pkg::PB_RST;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, cgs_pkg::ADDR_PB_LATCH))
        pb_latch_r <= wdata_i;
      if (hit(addr_i, cgs_pkg::ADDR_PB_DIR))
        pb_dir_r <= wdata_i;
      if (hit(addr_i, cgs_pkg::ADDR_PB_CFG_LO))
        pb_cfg_lo_r <= wdata_i;
      if (hit(addr_i, cgs_pkg::ADDR_PB_CFG_HI))
        pb_cfg_hi_r <= wdata_i;
      if (hit(addr_i, cgs_pkg::ADDR_PB_FSEL_LO))
        pb_fsel_lo_r <= wdata_i;
      if (hit(addr_i, cgs_pkg::ADDR_PB_FSEL_HI))
        pb_fsel_hi_r <= wdata_i;
    end
  end

  always_comb
  begin
    rd_nxt = 8'h00;
    case (addr_i)
      cgs_pkg::ADDR_FREQ_A:
      begin
        rd_nxt[cgs_pkg::DIV_LSB +: 2] = div_r;
        rd_nxt[cgs_pkg::SRC_BIT] = src_r;
        rd_nxt[cgs_pkg::FIXED_BIT] = 1'b1;
        rd_nxt[cgs_pkg::OUTDIV_LSB +: 2] = outdiv_r;
      end
      cgs_pkg::ADDR_FREQ_B:
      begin
        rd_nxt[cgs_pkg::SYSSEL_BIT] = syssel_r;
        rd_nxt[cgs_pkg::FAST_OSC_ENABLE_BIT] = fast_osc_enable_r;
        rd_nxt[cgs_pkg::LOCK_BIT] = lock_r;
      end
      cgs_pkg::ADDR_PB_LATCH: rd_nxt = pb_latch_r;
      cgs_pkg::ADDR_PB_DIR: rd_nxt = pb_dir_r;
      cgs_pkg::ADDR_PB_CFG_LO: rd_nxt = pb_cfg_lo_r;
      cgs_pkg::ADDR_PB_CFG_HI: rd_nxt = pb_cfg_hi_r;
      cgs_pkg::ADDR_PB_FSEL_LO: rd_nxt = pb_fsel_lo_r;
      cgs_pkg::ADDR_PB_FSEL_HI: rd_nxt = pb_fsel_hi_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_nxt;
    else
      rdata_o <= 8'h00;
  end

  // ---------------------------------------------------------------
  // stop mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      stopped_r <= 1'b0;
    else if (stop_release_i)
      stopped_r <= 1'b0;
    else if (stop_enter_i)
      stopped_r <= 1'b1;
  end

  // ---------------------------------------------------------------
  // slow clock sequencing
  // ---------------------------------------------------------------
  cgs_pkg::cgs_osc_t slow_st_r;
  logic [8:0] slow_cnt_r;
  logic [8:0] slow_lim_r;
  logic slow_ok;

  assign slow_ok = (slow_st_r == cgs_pkg::CGS_RUN);
  assign slow_osc_run_o = !stopped_r;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      slow_st_r <= cgs_pkg::CGS_WAIT;
      slow_cnt_r <= 9'h000;
      slow_lim_r <= 9'(SLOW_WAIT_RESET);
    end
    else
    begin
      case (slow_st_r)
        cgs_pkg::CGS_OFF:
        begin
          if (!stopped_r)
          begin
            slow_st_r <= cgs_pkg::CGS_WAIT;
            slow_cnt_r <= 9'h000;
            slow_lim_r <= 9'(SLOW_WAIT_STOP);
          end
        end
        cgs_pkg::CGS_WAIT:
        begin
          if (stopped_r)
            slow_st_r <= cgs_pkg::CGS_OFF;
          else if (slow_osc_tick_i)
          begin
            slow_cnt_r <= slow_cnt_r + 9'h001;
            if (slow_cnt_r + 9'h001 == slow_lim_r)
              slow_st_r <= cgs_pkg::CGS_RUN;
          end
        end
        cgs_pkg::CGS_RUN:
        begin
          if (stopped_r)
            slow_st_r <= cgs_pkg::CGS_OFF;
        end
        default: slow_st_r <= cgs_pkg::CGS_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // external clock input: sync and edge count
  // ---------------------------------------------------------------
  logic ext_a_s1_r;
  logic ext_a_s2_r;
  logic ext_b_s1_r;
  logic ext_b_s2_r;
  logic ext_prev_r;
  logic ext_lvl;
  logic ext_edge;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_a_s1_r <= 1'b0;
      ext_a_s2_r <= 1'b0;
      ext_b_s1_r <= 1'b0;
      ext_b_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_a_s1_r <= port_a_bit2_pin_i;
      ext_a_s2_r <= ext_a_s1_r;
      ext_b_s1_r <= port_b_bit6_pin_i;
      ext_b_s2_r <= ext_b_s1_r;
      ext_prev_r <= ext_lvl;
    end
  end

  // port A bit 2 has priority when both pins are clock inputs
  assign ext_lvl = pa2_clk_sel_i ? ext_a_s2_r : (pb6_clk_sel_i & ext_b_s2_r);
  assign ext_edge = ext_lvl & !ext_prev_r;
  assign pa2_gpio_ok_o = (src_r == cgs_pkg::SRC_PLL) | !pa2_clk_sel_i;
  assign pb6_gpio_ok_o = (src_r == cgs_pkg::SRC_PLL) | !pb6_clk_sel_i | pa2_clk_sel_i;

  // ---------------------------------------------------------------
  // fast clock sequencing
  // ---------------------------------------------------------------
  cgs_pkg::cgs_osc_t fast_st_r;
  logic [13:0] fast_cnt_r;
  logic [13:0] fast_lim;
  logic fast_tick;
  logic fast_ok;
  logic fast_go;

  assign fast_go = fast_osc_enable_r & !stopped_r;
  assign pll_run_o = fast_go & (src_r == cgs_pkg::SRC_PLL);
  assign fast_tick = (src_r == cgs_pkg::SRC_PLL) ? pll_tick_i : ext_edge;
  assign fast_lim = (src_r == cgs_pkg::SRC_PLL) ? 14'(FAST_WAIT_PLL) : 14'(FAST_WAIT_EXT);
  assign fast_ok = (fast_st_r == cgs_pkg::CGS_RUN);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fast_st_r <= cgs_pkg::CGS_OFF;
      fast_cnt_r <= 14'h0000;
    end
    else
    begin
      case (fast_st_r)
        cgs_pkg::CGS_OFF:
        begin
          fast_cnt_r <= 14'h0000;
          if (fast_go)
            fast_st_r <= cgs_pkg::CGS_WAIT;
        end
        cgs_pkg::CGS_WAIT:
        begin
          if (!fast_go)
            fast_st_r <= cgs_pkg::CGS_OFF;
          else if (fast_tick)
          begin
            fast_cnt_r <= fast_cnt_r + 14'h0001;
            if (fast_cnt_r + 14'h0001 == fast_lim)
              fast_st_r <= cgs_pkg::CGS_RUN;
          end
        end
        cgs_pkg::CGS_RUN:
        begin
          if (!fast_go)
            fast_st_r <= cgs_pkg::CGS_OFF;
        end
        default: fast_st_r <= cgs_pkg::CGS_OFF;
      endcase
    end
  end

  // lock flag: tolerance seen for a run of PLL ticks, cleared when PLL off
  logic [7:0] lock_cnt_r;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_cnt_r <= 8'h00;
      lock_r <= 1'b0;
    end
    else if (!pll_run_o || !pll_in_window_i)
    begin
      lock_cnt_r <= 8'h00;
      lock_r <= 1'b0;
    end
    else if (pll_tick_i && !lock_r)
    begin
      lock_cnt_r <= lock_cnt_r + 8'h01;
      if (lock_cnt_r + 8'h01 == 8'(PLL_LOCK_CYCLES))
        lock_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // divided fast clock and system clock enables
  // ---------------------------------------------------------------
  logic [2:0] div_cnt_r;
  logic [2:0] div_mask;
  logic fast_en_r;
  logic slow_en_r;

  always_comb
  begin
    div_mask = 3'h0;
    case (div_r)
      2'h0: div_mask = (src_r == cgs_pkg::SRC_PLL) ? 3'h1 : 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      2'h3: div_mask = 3'h7;
      default: div_mask = 3'h7;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_cnt_r <= 3'h0;
      fast_en_r <= 1'b0;
      slow_en_r <= 1'b0;
    end
    else
    begin
      fast_en_r <= 1'b0;
      slow_en_r <= slow_ok & slow_osc_tick_i;
      if (!fast_ok || !fast_go)
        div_cnt_r <= 3'h0;
      else if (fast_tick)
      begin
        div_cnt_r <= (div_cnt_r + 3'h1) & div_mask;
        fast_en_r <= ((div_cnt_r & div_mask) == div_mask);
      end
    end
  end

  assign slow_clock_o = slow_en_r;
  assign fast_clock_o = fast_en_r;

  // fast selection only takes effect once the fast supply is running
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sys_fast_o <= 1'b0;
    else if (!syssel_r)
      sys_fast_o <= 1'b0;
    else if (fast_ok)
      sys_fast_o <= 1'b1;
  end

  assign sys_tick_o = sys_fast_o ? fast_en_r : slow_en_r;
  assign cpu_stall_o = syssel_r ? !(fast_ok && sys_fast_o) : !slow_ok;

  // unused strap input kept for software-visible select path
  logic sel_unused;
  assign sel_unused = sys_clk_select_i;

  // ---------------------------------------------------------------
  // port B bit 7 slow clock output
  // ---------------------------------------------------------------
  logic pin7_clk_mode;
  logic pin7_lvl_r;
  assign pin7_clk_mode = pb_fsel_lo_r[cgs_pkg::PIN7] & !pb_fsel_hi_r[cgs_pkg::PIN7];

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pin7_lvl_r <= 1'b0;
    else if (slow_en_r)
      pin7_lvl_r <= !pin7_lvl_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      port_b_bit7_pin_o <= 1'b0;
      port_b_bit7_pin_oe_o <= 1'b0;
    end
    else
    begin
      port_b_bit7_pin_o <= pin7_clk_mode ? pin7_lvl_r : pb_latch_r[cgs_pkg::PIN7];
      port_b_bit7_pin_oe_o <= !pb_dir_r[cgs_pkg::PIN7] & pb_cfg_lo_r[cgs_pkg::PIN7] & pb_cfg_hi_r[cgs_pkg::PIN7];
    end
  end
endmodule
`default_nettype wire

// ### common/cgs_pkg.sv
/*
  cgs_pkg: register map, field layout, reset values and stabilization counts
  of the clock generation sequencer.
  Assumes byte-addressed special function registers on a 16-bit address bus.
*/
`default_nettype none
package cgs_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [15:0] ADDR_FREQ_A = 16'hF002;
  localparam logic [15:0] ADDR_FREQ_B = 16'hF003;
  localparam logic [15:0] ADDR_PB_LATCH = 16'hF258;
  localparam logic [15:0] ADDR_PB_DIR = 16'hF259;
  localparam logic [15:0] ADDR_PB_CFG_LO = 16'hF25A;
  localparam logic [15:0] ADDR_PB_CFG_HI = 16'hF25B;
  localparam logic [15:0] ADDR_PB_FSEL_LO = 16'hF25C;
  localparam logic [15:0] ADDR_PB_FSEL_HI = 16'hF25D;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int DIV_LSB = 0;
  localparam int SRC_BIT = 2;
  localparam int FIXED_BIT = 3;
  localparam int OUTDIV_LSB = 4;
  localparam int SYSSEL_BIT = 0;
  localparam int FAST_OSC_ENABLE_BIT = 1;
  localparam int LOCK_BIT = 7;
  localparam int PIN7 = 7;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] FREQ_A_RST = 8'h3B;
  localparam logic [7:0] FREQ_B_RST = 8'h00;
  localparam logic [7:0] PB_RST = 8'h00;
  localparam logic [1:0] DIV_RST = 2'h3;
  localparam logic [1:0] OUTDIV_RST = 2'h3;
  // -----------------------------------------------------------------
  // stabilization counts
  // -----------------------------------------------------------------
  localparam int SLOW_WAIT_RESET = 256;
  localparam int SLOW_WAIT_STOP = 32;
  localparam int FAST_WAIT_PLL = 8192;
  localparam int FAST_WAIT_EXT = 128;
  localparam int PLL_MULT = 512;
  localparam int PLL_LOCK_CYCLES = 64;
  localparam logic SRC_PLL = 1'b0;
  localparam logic SRC_EXT = 1'b1;
  typedef enum logic [1:0] {CGS_OFF, CGS_WAIT, CGS_RUN} cgs_osc_t;
endpackage
`default_nettype wire

// ### verification/cgs_top_asserts.sv
/*
  cgs_top_asserts: port-level checks of the clock generation sequencer.
  Assumes it is bound to cgs_top and that there is one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module cgs_top_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control inputs
  input wire logic wr_i,
  input wire logic stop_enter_i,
  input wire logic stop_release_i,
  input wire logic slow_osc_tick_i,
  // watched outputs
  input wire logic slow_osc_run_o,
  input wire logic pll_run_o,
  input wire logic pa2_gpio_ok_o,
  input wire logic pb6_gpio_ok_o,
  input wire logic slow_clock_o,
  input wire logic fast_clock_o,
  input wire logic sys_tick_o,
  input wire logic sys_fast_o,
  input wire logic cpu_stall_o,
  input wire logic port_b_bit7_pin_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_stop_slow;
    stop_enter_i && !stop_release_i |=> !slow_osc_run_o;
  endproperty
  a_stop_slow: assert property (p_stop_slow) else $error("slow osc still runs in stop");
  property p_stop_pll;
    stop_enter_i && !stop_release_i |=> !pll_run_o;
  endproperty
  a_stop_pll: assert property (p_stop_pll) else $error("pll still runs in stop");
  property p_stop_fast;
    stop_enter_i && !stop_release_i |=> ##1 !fast_clock_o;
  endproperty
  a_stop_fast: assert property (p_stop_fast) else $error("fast clock still gated on");
  property p_slow_src;
    slow_clock_o |-> $past(slow_osc_tick_i);
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("slow clock without tick");
  // registered gate may still pass the last tick, so look one cycle on
  property p_slow_quiet;
    !slow_osc_run_o |=> !slow_clock_o;
  endproperty
  a_slow_quiet: assert property (p_slow_quiet) else $error("slow clock while halted");
  property p_sys_sel;
    sys_tick_o |-> (sys_fast_o ? fast_clock_o : slow_clock_o);
  endproperty
  a_sys_sel: assert property (p_sys_sel) else $error("system tick from wrong source");
  property p_pll_gpio;
    pll_run_o |-> pa2_gpio_ok_o && pb6_gpio_ok_o;
  endproperty
  a_pll_gpio: assert property (p_pll_gpio) else $error("clock pin taken in pll mode");
  property p_rel_stall;
    $rose(slow_osc_run_o) |-> cpu_stall_o;
  endproperty
  a_rel_stall: assert property (p_rel_stall) else $error("cpu runs before clock supply");
  property p_rel_gate;
    $rose(slow_osc_run_o) |-> !slow_clock_o [*8];
  endproperty
  a_rel_gate: assert property (p_rel_gate) else $error("slow clock before wait");
  property p_pin_src;
    $changed(port_b_bit7_pin_o) |-> $past(slow_clock_o) || $past(slow_clock_o, 2) || $past(wr_i) || $past(wr_i, 2);
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin moved without cause");
endmodule
bind cgs_top cgs_top_asserts u_cgs_top_asserts (
  .clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .stop_enter_i(stop_enter_i),
  .stop_release_i(stop_release_i), .slow_osc_tick_i(slow_osc_tick_i), .slow_osc_run_o(slow_osc_run_o),
  .pll_run_o(pll_run_o), .pa2_gpio_ok_o(pa2_gpio_ok_o), .pb6_gpio_ok_o(pb6_gpio_ok_o),
  .slow_clock_o(slow_clock_o), .fast_clock_o(fast_clock_o), .sys_tick_o(sys_tick_o),
  .sys_fast_o(sys_fast_o), .cpu_stall_o(cpu_stall_o), .port_b_bit7_pin_o(port_b_bit7_pin_o)
);
`default_nettype wire

// ### verification/cgs_osc_model.sv
/*
  cgs_osc_model: slow RC core, PLL core and external clock source.
  Assumes run requests from cgs_top; ticks are pulses on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module cgs_osc_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic slow_run_i,
  input wire logic pll_run_i,
  input wire logic win_bad_i,
  input wire logic [1:0] ext_sel_i,
  // cores and pins
  output logic slow_tick_o,
  output logic pll_tick_o,
  output logic in_window_o,
  output logic pa2_o,
  output logic pb6_o
);
  logic [1:0] slow_div_r;
  logic pll_ph_r;
  logic [1:0] ext_div_r;
  logic ext_r;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      slow_div_r <= 2'h0;
      pll_ph_r <= 1'b0;
      ext_div_r <= 2'h0;
      ext_r <= 1'b0;
    end
    else
    begin
      slow_div_r <= (slow_div_r == 2'h2) ? 2'h0 : slow_div_r + 2'h1;
      pll_ph_r <= pll_run_i & ~pll_ph_r;
      ext_div_r <= ext_div_r + 2'h1;
      if (ext_div_r == 2'h3)
        ext_r <= ~ext_r;
    end
  end
  assign slow_tick_o = slow_run_i & (slow_div_r == 2'h2);
  assign pll_tick_o = pll_run_i & pll_ph_r;
  assign in_window_o = pll_run_i & ~win_bad_i;
  // idle pins are driven low, never left open; period of 8 cycles stays slow
  assign pa2_o = (ext_sel_i == 2'h1) & ext_r;
  assign pb6_o = (ext_sel_i == 2'h2) & ext_r;
endmodule
`default_nettype wire

// ### verification/cgs_top_tb.sv
/*
  cgs_top_tb: self-checking bench for the clock generation sequencer.
  Assumes cgs_pkg, cgs_top, cgs_osc_model and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module cgs_top_tb;
  localparam int PLL_W = 16;
  logic clk_i, resetn_i, wr_i, rd_i, stop_enter_i, stop_release_i, win_bad, pa2_q, p0;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic [1:0] ext_sel;
  logic slow_osc_tick_i, pll_tick_i, pll_in_window_i, slow_osc_run_o, pll_run_o;
  logic port_a_bit2_pin_i, port_b_bit6_pin_i, pa2_clk_sel_i, pb6_clk_sel_i, pa2_gpio_ok_o, pb6_gpio_ok_o;
  logic slow_clock_o, fast_clock_o, sys_tick_o, sys_fast_o, cpu_stall_o, port_b_bit7_pin_o, port_b_bit7_pin_oe_o;
  int error_cnt = 0, n_tests = 0, n_slow = 0, n_pll = 0, n_ext = 0, base, t0, i;
  cgs_top #(.FAST_WAIT_PLL(PLL_W), .PLL_LOCK_CYCLES(4)) u_cgs_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .stop_enter_i(stop_enter_i), .stop_release_i(stop_release_i), .sys_clk_select_i(1'b0),
    .slow_osc_tick_i(slow_osc_tick_i), .pll_tick_i(pll_tick_i), .pll_in_window_i(pll_in_window_i),
    .slow_osc_run_o(slow_osc_run_o), .pll_run_o(pll_run_o), .port_a_bit2_pin_i(port_a_bit2_pin_i),
    .port_b_bit6_pin_i(port_b_bit6_pin_i), .pa2_clk_sel_i(pa2_clk_sel_i), .pb6_clk_sel_i(pb6_clk_sel_i),
    .pa2_gpio_ok_o(pa2_gpio_ok_o), .pb6_gpio_ok_o(pb6_gpio_ok_o), .slow_clock_o(slow_clock_o),
    .fast_clock_o(fast_clock_o), .sys_tick_o(sys_tick_o), .sys_fast_o(sys_fast_o), .cpu_stall_o(cpu_stall_o),
    .port_b_bit7_pin_o(port_b_bit7_pin_o), .port_b_bit7_pin_oe_o(port_b_bit7_pin_oe_o));
  cgs_osc_model u_cgs_osc_model (.clk_i(clk_i), .resetn_i(resetn_i), .slow_run_i(slow_osc_run_o),
    .pll_run_i(pll_run_o), .win_bad_i(win_bad), .ext_sel_i(ext_sel), .slow_tick_o(slow_osc_tick_i),
    .pll_tick_o(pll_tick_i), .in_window_o(pll_in_window_i), .pa2_o(port_a_bit2_pin_i), .pb6_o(port_b_bit6_pin_i));
  // ---------------------------------------------------------------
  // clock, event counters, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    pa2_q <= port_a_bit2_pin_i;
    n_slow <= n_slow + int'(slow_osc_tick_i);
    n_pll <= n_pll + int'(pll_tick_i);
    n_ext <= n_ext + int'(port_a_bit2_pin_i & ~pa2_q);
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task automatic wait_pulse(input bit fast);
    i = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    while ((fast ? fast_clock_o : slow_clock_o) !== 1'b1 && i < 5000);
    chk(8'(i < 5000), 8'h01);
  endtask
  // gate opening may trail the last counted pulse by the divider phase
  task automatic rng(input int got, input int lo);
    chk(8'(got >= lo && got <= lo + 3), 8'h01);
  endtask
  function automatic int exp_per(input logic [1:0] c);
    return (c == 2'h0) ? 4 : 2 * (1 << c);
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    resetn_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    stop_enter_i = 1'b0;
    stop_release_i = 1'b0;
    pa2_clk_sel_i = 1'b0;
    pb6_clk_sel_i = 1'b0;
    win_bad = 1'b0;
    ext_sel = 2'h0;
    void'($urandom(5));
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk({7'h0, cpu_stall_o}, 8'h01);
    rdc(cgs_pkg::ADDR_FREQ_A, 8'h3B);
    rdc(cgs_pkg::ADDR_FREQ_B, 8'h00);
    for (t0 = 0; t0 < 6; t0++)
      rdc(cgs_pkg::ADDR_PB_LATCH + 16'(t0), 8'h00);
    rdc(16'hF004, 8'h00);
    wait_pulse(1'b0);
    rng(n_slow, cgs_pkg::SLOW_WAIT_RESET);
    chk({7'h0, cpu_stall_o}, 8'h00);
    for (t0 = 0; t0 < 6; t0++)
    begin
      d = 8'($urandom);
      wr(cgs_pkg::ADDR_PB_LATCH + 16'(t0), d);
      rdc(cgs_pkg::ADDR_PB_LATCH + 16'(t0), d);
    end
    wr(16'hF004, 8'hFF);
    rdc(16'hF004, 8'h00);
    wr(cgs_pkg::ADDR_FREQ_A, 8'h39);
    base = n_pll;
    wr(cgs_pkg::ADDR_FREQ_B, 8'h02);
    wait_pulse(1'b1);
    rng(n_pll - base, PLL_W);
    rdc(cgs_pkg::ADDR_FREQ_B, 8'h82);
    wr(cgs_pkg::ADDR_FREQ_A, 8'h3D);
    rdc(cgs_pkg::ADDR_FREQ_A, 8'h39);
    for (t0 = 0; t0 < 4; t0++)
    begin
      wr(cgs_pkg::ADDR_FREQ_A, 8'h38 | 8'(t0));
      wait_pulse(1'b1);
      wait_pulse(1'b1);
      base = int'($time / 100);
      wait_pulse(1'b1);
      chk(8'(int'($time / 100) - base), 8'(exp_per(2'(t0))));
    end
    wr(cgs_pkg::ADDR_FREQ_A, 8'h39);
    wr(cgs_pkg::ADDR_FREQ_B, 8'h03);
    repeat (40) @(posedge clk_i);
    #1;
    chk({6'h0, sys_fast_o, cpu_stall_o}, 8'h02);
    rdc(cgs_pkg::ADDR_FREQ_B, 8'h83);
    @(posedge clk_i);
    win_bad <= 1'b1;
    rdc(cgs_pkg::ADDR_FREQ_B, 8'h03);
    @(posedge clk_i);
    win_bad <= 1'b0;
    stop_enter_i <= 1'b1;
    @(posedge clk_i);
    stop_enter_i <= 1'b0;
    #1;
    chk({6'h0, slow_osc_run_o, pll_run_o}, 8'h00);
    repeat (20) @(posedge clk_i);
    stop_release_i <= 1'b1;
    base = n_slow;
    t0 = n_pll;
    @(posedge clk_i);
    stop_release_i <= 1'b0;
    #1;
    chk({7'h0, cpu_stall_o}, 8'h01);
    wait_pulse(1'b1);
    rng(n_pll - t0, PLL_W);
    wait_pulse(1'b0);
    rng(n_slow - base, cgs_pkg::SLOW_WAIT_STOP);
    wr(cgs_pkg::ADDR_FREQ_B, 8'h01);
    rdc(cgs_pkg::ADDR_FREQ_B, 8'h00);
    chk({7'h0, sys_fast_o}, 8'h00);
    wr(cgs_pkg::ADDR_FREQ_A, 8'h3D);
    @(posedge clk_i);
    pa2_clk_sel_i <= 1'b1;
    pb6_clk_sel_i <= 1'b1;
    ext_sel <= 2'h2;
    wr(cgs_pkg::ADDR_FREQ_B, 8'h02);
    p0 = 1'b0;
    repeat (400)
    begin
      @(posedge clk_i);
      #1;
      p0 = p0 | fast_clock_o;
    end
    chk({5'h0, p0, pa2_gpio_ok_o, pb6_gpio_ok_o}, 8'h01);
    @(posedge clk_i);
    ext_sel <= 2'h1;
    base = n_ext;
    wait_pulse(1'b1);
    rng(n_ext - base, cgs_pkg::FAST_WAIT_EXT);
    wr(cgs_pkg::ADDR_PB_FSEL_LO, 8'h80 | 8'($urandom));
    wr(cgs_pkg::ADDR_PB_FSEL_HI, 8'h7F & 8'($urandom));
    wr(cgs_pkg::ADDR_PB_CFG_LO, 8'h80 | 8'($urandom));
    wr(cgs_pkg::ADDR_PB_CFG_HI, 8'h80 | 8'($urandom));
    wr(cgs_pkg::ADDR_PB_DIR, 8'h7F & 8'($urandom));
    wr(cgs_pkg::ADDR_PB_LATCH, 8'($urandom));
    for (t0 = 0; t0 < 5; t0++)
    begin
      wait_pulse(1'b0);
      repeat (2) @(posedge clk_i);
      #1;
      if (t0 > 0)
        chk({7'h0, port_b_bit7_pin_o}, {7'h0, ~p0});
      p0 = port_b_bit7_pin_o;
    end
    chk({7'h0, port_b_bit7_pin_oe_o}, 8'h01);
    wr(cgs_pkg::ADDR_PB_DIR, 8'h80);
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h0, port_b_bit7_pin_oe_o}, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
